// ===== hw/pdb_pkg.sv
// Package: constants for the CC line BMC physical layer
package pdb_pkg;

  // =====================================================================
  // Timing
  // =====================================================================
  localparam int CLK_HZ         = 20_000_000;
  localparam int BIT_RATE_HZ    = 300_000;
  // Cycles per half bit interval, rounded down so the rate never runs slow
  localparam int HALF_BIT_CYC   = CLK_HZ / (2 * BIT_RATE_HZ);
  localparam int CNT_W          = 8;
  // Receive: a gap longer than this marks a full interval (zero bit)
  localparam int RX_THR_CYC     = (3 * HALF_BIT_CYC) / 2;
  // Receive: no edge for this long ends the packet
  localparam int RX_IDLE_CYC    = 3 * HALF_BIT_CYC;
  // Low level held before the first preamble edge
  localparam int PRE_LOW_CYC    = HALF_BIT_CYC;

  // =====================================================================
  // Reset values
  // =====================================================================
  localparam logic RST_LINE     = 1'b0;
  // Released CC wire rests at its attach bias, read as high
  localparam logic RST_CC_IN    = 1'b1;

  // =====================================================================
  // Transmit states
  // =====================================================================
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_LOW   = 2'b01,
    TX_BITS  = 2'b10,
    TX_CLOSE = 2'b11
  } pdb_tx_state_t;

endpackage : pdb_pkg

// ===== hw/pdb_cc_phy.sv
// Module: BMC encoder, decoder and CC pin driver for one Type-C port
// =====================================================================
module pdb_cc_phy #(
  parameter int HALF_CYC = pdb_pkg::HALF_BIT_CYC
) (
  input  wire logic CORE_CLK,
  input  wire logic ARST_N,
  input  wire logic ORIENT_FLIP,     // Orientation: 0 uses line a, 1 line b
  input  wire logic TX_VALID,        // Bit offered by the protocol layer
  input  wire logic TX_DATA,
  input  wire logic TX_LAST,         // Marks the final end-of-packet bit
  output logic      TX_READY,        // Pulse: offered bit taken
  output logic      TX_BUSY,
  output logic      CC_LINE_A_O,
  output logic      CC_LINE_A_OE,
  input  wire logic CC_LINE_A_I,
  output logic      CC_LINE_B_O,
  output logic      CC_LINE_B_OE,
  input  wire logic CC_LINE_B_I,
  output logic      RX_VALID,        // Pulse: one decoded bit
  output logic      RX_DATA,
  output logic      RX_ACTIVE
);

  // =====================================================================
  // Transmit side
  // =====================================================================
  pdb_pkg::pdb_tx_state_t   st_r, st_nxt;
  logic [pdb_pkg::CNT_W-1:0] tcnt_r, tcnt_nxt;
  logic                     half_r, half_nxt;   // 1 in second half of bit
  logic                     bit_r, bit_nxt;
  logic                     last_r, last_nxt;
  logic                     line_r, line_nxt;
  logic                     take_nxt;

  localparam logic [pdb_pkg::CNT_W-1:0] HC_M1 = pdb_pkg::CNT_W'(HALF_CYC - 1);
  localparam logic [pdb_pkg::CNT_W-1:0] PL_M1 = pdb_pkg::CNT_W'(pdb_pkg::PRE_LOW_CYC - 1);

  wire tick = (tcnt_r == '0);

  // Next-state logic; a bit is taken at the end of the low preamble and at each interval boundary until the packet closes
  always_comb begin
    st_nxt   = st_r;
    tcnt_nxt = tick ? HC_M1 : tcnt_r - 1'b1;
    half_nxt = half_r;
    bit_nxt  = bit_r;
    last_nxt = last_r;
    line_nxt = line_r;
    take_nxt = 1'b0;
    unique case (st_r)
      pdb_pkg::TX_IDLE: begin
        line_nxt = pdb_pkg::RST_LINE;
        if (TX_VALID) begin
          st_nxt   = pdb_pkg::TX_LOW;
          tcnt_nxt = PL_M1;
          line_nxt = 1'b0;
        end
      end
      pdb_pkg::TX_LOW: begin
        if (tick) begin
          st_nxt   = pdb_pkg::TX_BITS;
          take_nxt = 1'b1;
          bit_nxt  = TX_DATA;
          last_nxt = TX_LAST;
          half_nxt = 1'b0;
          line_nxt = ~line_r;
        end
      end
      pdb_pkg::TX_BITS: begin
        if (tick && !half_r) begin
          half_nxt = 1'b1;
          if (bit_r)
            line_nxt = ~line_r;
        end else if (tick) begin
          half_nxt = 1'b0;
          line_nxt = ~line_r;
          if (last_r || !TX_VALID) begin
            st_nxt = pdb_pkg::TX_CLOSE;
          end else begin
            take_nxt = 1'b1;
            bit_nxt  = TX_DATA;
            last_nxt = TX_LAST;
          end
        end
      end
      pdb_pkg::TX_CLOSE: begin
        // Closing edge is out; hold it a half interval, then release
        if (tick)
          st_nxt = pdb_pkg::TX_IDLE;
      end
    endcase
  end

  wire driving_nxt = (st_nxt != pdb_pkg::TX_IDLE);

  // Transmit registers; output enable follows state, never a stale level
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r         <= pdb_pkg::TX_IDLE;
      tcnt_r       <= '0;
      half_r       <= 1'b0;
      bit_r        <= 1'b0;
      last_r       <= 1'b0;
      line_r       <= pdb_pkg::RST_LINE;
      TX_READY     <= 1'b0;
      TX_BUSY      <= 1'b0;
      CC_LINE_A_O  <= 1'b0;
      CC_LINE_A_OE <= 1'b0;
      CC_LINE_B_O  <= 1'b0;
      CC_LINE_B_OE <= 1'b0;
    end else begin
      st_r         <= st_nxt;
      tcnt_r       <= tcnt_nxt;
      half_r       <= half_nxt;
      bit_r        <= bit_nxt;
      last_r       <= last_nxt;
      line_r       <= line_nxt;
      TX_READY     <= take_nxt;
      TX_BUSY      <= driving_nxt;
      CC_LINE_A_O  <= line_nxt & ~ORIENT_FLIP;
      CC_LINE_A_OE <= driving_nxt & ~ORIENT_FLIP;
      CC_LINE_B_O  <= line_nxt & ORIENT_FLIP;
      CC_LINE_B_OE <= driving_nxt & ORIENT_FLIP;
    end
  end

  // =====================================================================
  // Receive side
  // =====================================================================
  logic                      a_s1_r, a_s2_r, b_s1_r, b_s2_r, s3_r;
  logic [pdb_pkg::CNT_W-1:0] gap_r;
  logic                      pend_r;    // Mid edge seen in this interval
  logic                      act_r;

  // Both pins are synchronised first, so the select never sees a raw pin
  wire cc_sel  = ORIENT_FLIP ? b_s2_r : a_s2_r;
  wire edge_w  = (cc_sel != s3_r) && !TX_BUSY;
  wire long_w  = (gap_r > pdb_pkg::CNT_W'(pdb_pkg::RX_THR_CYC));
  wire idle_w  = (gap_r >= pdb_pkg::CNT_W'(pdb_pkg::RX_IDLE_CYC));

  // Two-stage synchroniser, then gap timing between edges
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      // Idle level of the wire, so no false edge follows reset
      a_s1_r   <= pdb_pkg::RST_CC_IN;
      a_s2_r   <= pdb_pkg::RST_CC_IN;
      b_s1_r   <= pdb_pkg::RST_CC_IN;
      b_s2_r   <= pdb_pkg::RST_CC_IN;
      s3_r     <= pdb_pkg::RST_CC_IN;
      gap_r    <= '0;
      pend_r   <= 1'b0;
      act_r    <= 1'b0;
      RX_VALID <= 1'b0;
      RX_DATA  <= 1'b0;
      RX_ACTIVE <= 1'b0;
    end else begin
      a_s1_r   <= CC_LINE_A_I;
      a_s2_r   <= a_s1_r;
      b_s1_r   <= CC_LINE_B_I;
      b_s2_r   <= b_s1_r;
      s3_r     <= cc_sel;
      RX_VALID <= 1'b0;
      if (edge_w) begin
        gap_r <= '0;
        // First edge only starts timing, so a lost first edge before a zero bit costs only that bit
        if (act_r && long_w) begin
          RX_VALID <= 1'b1;
          RX_DATA  <= 1'b0;
          pend_r   <= 1'b0;
        end else if (act_r && pend_r) begin
          RX_VALID <= 1'b1;
          RX_DATA  <= 1'b1;
          pend_r   <= 1'b0;
        end else if (act_r) begin
          pend_r   <= 1'b1;
        end
        act_r     <= 1'b1;
        RX_ACTIVE <= 1'b1;
      end else if (idle_w) begin
        act_r     <= 1'b0;
        pend_r    <= 1'b0;
        RX_ACTIVE <= 1'b0;
      end else begin
        gap_r <= gap_r + 1'b1;
      end
    end
  end

  // =====================================================================
  // Checks
  // =====================================================================
  property p_oe_idle;
    @(posedge CORE_CLK) disable iff (!ARST_N)
    (st_r == pdb_pkg::TX_IDLE) |-> !CC_LINE_A_OE && !CC_LINE_B_OE;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("driver on while idle");

  property p_one_pin;
    @(posedge CORE_CLK) disable iff (!ARST_N)
    !(CC_LINE_A_OE && CC_LINE_B_OE);
  endproperty
  a_one_pin: assert property (p_one_pin) else $error("both CC pins driven");

  property p_drive_busy;
    @(posedge CORE_CLK) disable iff (!ARST_N)
    TX_BUSY |-> (CC_LINE_A_OE || CC_LINE_B_OE);
  endproperty
  a_drive_busy: assert property (p_drive_busy) else $error("busy but not driving");

  property p_pre_low;
    @(posedge CORE_CLK) disable iff (!ARST_N)
    (st_r == pdb_pkg::TX_LOW) |-> !line_r;
  endproperty
  a_pre_low: assert property (p_pre_low) else $error("preamble not low");

  property p_boundary;
    @(posedge CORE_CLK) disable iff (!ARST_N)
    (st_r == pdb_pkg::TX_BITS && tick && half_r) |=> (line_r != $past(line_r));
  endproperty
  a_boundary: assert property (p_boundary) else $error("no boundary edge");

  property p_mid_one;
    @(posedge CORE_CLK) disable iff (!ARST_N)
    (st_r == pdb_pkg::TX_BITS && tick && !half_r) |=>
      ((line_r != $past(line_r)) == $past(bit_r));
  endproperty
  a_mid_one: assert property (p_mid_one) else $error("bad mid edge");

  property p_close;
    @(posedge CORE_CLK) disable iff (!ARST_N)
    (st_r == pdb_pkg::TX_BITS && st_nxt == pdb_pkg::TX_CLOSE) |=>
      (line_r != $past(line_r)) ##1 (st_r == pdb_pkg::TX_CLOSE);
  endproperty
  a_close: assert property (p_close) else $error("no closing edge");

  property p_no_self_rx;
    @(posedge CORE_CLK) disable iff (!ARST_N)
    $rose(TX_BUSY) |-> ##1 !RX_VALID [*3];
  endproperty
  a_no_self_rx: assert property (p_no_self_rx) else $error("decoded own tx");

  // Any cycle spent driving must leave the decoder silent on the next one
  property p_rx_mute;
    @(posedge CORE_CLK) disable iff (!ARST_N)
    TX_BUSY |=> !RX_VALID;
  endproperty
  a_rx_mute: assert property (p_rx_mute) else $error("decoded while driving");

  c_tx_pkt: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
    st_r == pdb_pkg::TX_CLOSE);
  c_rx_one: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
    RX_VALID && RX_DATA);
  c_rx_zero: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
    RX_VALID && !RX_DATA);

endmodule : pdb_cc_phy

// ===== testbench/pdb_peer.sv
// Peer port model: sends BMC frames on the shared CC wire
module pdb_peer #(
  parameter int HALF = 33
) (
  input  wire logic CLK,
  output logic      O,
  output logic      OE
);
  timeunit 1ns;
  timeprecision 100ps;
  // Released at start so the bias owns the wire
  initial begin
    O = 1'b0;
    OE = 1'b0;
  end
  // Changes land just after the edge
  task automatic tick(input int k);
    repeat (k) @(posedge CLK);
    #2;
  endtask : tick
  // Long low first so the far receiver times out and starts clean
  task automatic send(input logic [15:0] b, input int n, input bit lose);
    OE = 1'b1;
    O = 1'b0;
    tick(120);
    for (int i = 0; i < n; i++) begin
      if (!(lose && i == 0)) O = ~O;
      tick(HALF);
      if (b[i]) O = ~O;
      tick(HALF);
    end
    O = ~O; // Closing edge
    tick(HALF);
    OE = 1'b0;
  endtask : send
endmodule : pdb_peer

// ===== testbench/tb.sv
// Testbench for the CC line BMC physical layer
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int H = pdb_pkg::HALF_BIT_CYC;
  typedef struct packed {logic flip; logic pl; logic [3:0] n; logic [15:0] b;} pdb_row_t;
  logic clk = 1'b0, arst_n = 1'b0, flip = 1'b0, pl = 1'b0;
  logic tv = 1'b0, td = 1'b0, tl = 1'b0, p_o = 1'b0, p_oe = 1'b0;
  wire logic rdy, busy, ao, aoe, bo, boe, rv, rd, ract, po, poe;
  int err_count = 0;
  int n_tests = 0;
  int t = 0;
  int gq[$];
  int eq[$];
  logic rq[$];
  // Released wire floats to the attach bias, seen as high
  wire logic a_w = aoe ? ao : (poe && !pl) ? po : 1'b1;
  wire logic b_w = boe ? bo : (poe && pl) ? po : 1'b1;
  wire logic so = flip ? bo : ao;
  wire logic soe = flip ? boe : aoe;
  wire logic noe = flip ? aoe : boe;
  // Rows: orientation, peer line, bit count, bits sent first at bit 0
  pdb_row_t rows [4] = '{'{1'b0, 1'b0, 4'h8, 16'h00B4}, '{1'b0, 1'b0, 4'h1, 16'h0001},
                         '{1'b1, 1'b1, 4'h6, 16'h002A}, '{1'b1, 1'b0, 4'h5, 16'h0013}};

  always #25 clk = ~clk;

  pdb_cc_phy #(.HALF_CYC(H)) u_pdb_cc_phy (
    .CORE_CLK(clk), .ARST_N(arst_n), .ORIENT_FLIP(flip), .TX_VALID(tv), .TX_DATA(td),
    .TX_LAST(tl), .TX_READY(rdy), .TX_BUSY(busy), .CC_LINE_A_O(ao), .CC_LINE_A_OE(aoe),
    .CC_LINE_A_I(a_w), .CC_LINE_B_O(bo), .CC_LINE_B_OE(boe), .CC_LINE_B_I(b_w),
    .RX_VALID(rv), .RX_DATA(rd), .RX_ACTIVE(ract));
  pdb_peer #(.HALF(H)) u_pdb_peer (.CLK(clk), .O(po), .OE(poe));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : tick
  // Bounded wait on READY (0) or BUSY (1); a pulse is seen since we look every cycle
  task automatic wait_sig(input bit w, input logic lvl);
    for (int k = 0; (w ? busy : rdy) !== lvl; k++) begin
      if (k > 300) begin
        chk("timeout", 16'h0000, 16'h0001);
        close_out();
      end
      tick(1);
    end
  endtask : wait_sig
  // Wire monitor: edge spacing while we drive, ownership, received bits
  always @(posedge clk) begin
    t = t + 1;
    if (soe && !p_oe) begin
      t = 0;
      chk("start low", 16'h0000, 16'(so));
    end
    if (soe && p_oe && so !== p_o) begin
      gq.push_back(t);
      t = 0;
    end
    if (!soe && p_oe) gq.push_back(t);
    if (arst_n && noe !== 1'b0) chk("other oe", 16'h0000, 16'(noe));
    if (soe && rv) chk("rx own", 16'h0000, 16'(rv));
    if (poe && (pl ? boe : aoe)) chk("clash", 16'h0000, 16'h0001);
    if (rv === 1'b1) rq.push_back(rd);
    p_oe = soe;
    p_o = so;
  end
  // Send a packet; expected gaps: pre-low, bit halves or wholes, closing hold
  task automatic tx(input logic [15:0] b, input int n, input bit use_last);
    eq = {H};
    gq = {};
    for (int i = 0; i < n; i++) begin
      if (b[i]) eq = {eq, H, H};
      else eq.push_back(2 * H);
    end
    eq.push_back(H);
    for (int i = 0; i < n; i++) begin
      tv = 1'b1;
      td = b[i];
      tl = use_last && (i == n - 1);
      wait_sig(1'b0, 1'b1);
      tick(1);
    end
    tv = 1'b0;
    tl = 1'b0;
    wait_sig(1'b1, 1'b0);
    tick(2);
    chk("edges", 16'(eq.size()), 16'(gq.size()));
    foreach (eq[i]) chk("gap", 16'(eq[i]), 16'(gq[i]));
  endtask : tx
  // Peer sends; expect the last m of n bits back
  task automatic rx(input logic [15:0] b, input int n, input bit lose, input int m);
    rq = {};
    u_pdb_peer.send(b, n, lose);
    chk("rx active", 16'(m != 0), 16'(ract));
    tick(150);
    chk("rx idle", 16'h0000, 16'(ract));
    chk("rx count", 16'(m), 16'(rq.size()));
    for (int i = 0; i < m; i++) chk("rx bit", 16'(b[i + n - m]), 16'(rq[i]));
  endtask : rx
  // Main sequence: reset, table, then the awkward cases
  initial begin
    repeat (12) @(posedge clk);
    #2;
    chk("reset", 16'h0000, 16'({rdy, busy, aoe, boe, rv, ract}));
    arst_n = 1'b1;
    tick(2);
    foreach (rows[i]) begin
      flip = rows[i].flip;
      pl = rows[i].pl;
      tx(rows[i].b, rows[i].n, 1'b1);
      rx(rows[i].b, rows[i].n, 1'b0, (rows[i].pl == rows[i].flip) ? rows[i].n : 0);
    end
    flip = 1'b0;
    pl = 1'b0;
    tx(16'h0005, 3, 1'b0);
    // Reset in mid-packet: outputs clear at once and the wire is let go
    tv = 1'b1;
    td = 1'b1;
    tick(40);
    arst_n = 1'b0;
    tv = 1'b0;
    #5;
    chk("reset mid", 16'h0000, 16'({rdy, busy, aoe, boe, rv, ract}));
    tick(2);
    arst_n = 1'b1;
    tick(2);
    rx(16'h00AA, 8, 1'b1, 7);
    close_out();
  end
endmodule : tb
